// ### core/asfi_pkg.sv
// Constants, register map and carrier types of the channel-0 FIFO status and interrupt block
package asfi_pkg;
    localparam int ASFI_AW = 12;
    localparam int ASFI_DW = 32;
    localparam int ASFI_NCH = 4;
    localparam int ASFI_CHW = 2;
    localparam int ASFI_LVLW = 5;
    localparam int ASFI_TRGW = 4;
    localparam int ASFI_STW = 6;

    localparam logic [ASFI_AW-1:0] ASFI_OFF_STATUS = 12'h038;
    localparam logic [ASFI_AW-1:0] ASFI_OFF_MASK = 12'h03C;
    localparam logic [ASFI_AW-1:0] ASFI_OFF_RX_OVR = 12'h040;
    localparam logic [ASFI_AW-1:0] ASFI_OFF_TX_OVR = 12'h044;
    localparam logic [ASFI_AW-1:0] ASFI_OFF_RX_TRIG = 12'h048;
    localparam logic [ASFI_AW-1:0] ASFI_OFF_TX_TRIG = 12'h04C;
    localparam logic [ASFI_AW-1:0] ASFI_OFF_RX_FLUSH = 12'h050;
    localparam logic [ASFI_AW-1:0] ASFI_OFF_TX_FLUSH = 12'h054;
    localparam logic [ASFI_AW-1:0] ASFI_OFF_CLEAR = 12'h058;
    localparam logic [ASFI_AW-1:0] ASFI_OFF_RX_DMA = 12'h1C0;

    localparam int ASFI_B_RX_DATA_AVAIL_FLAG = 0;
    localparam int ASFI_B_RX_OVERRUN_FLAG = 1;
    localparam int ASFI_B_TX_EMPTY_TRIGGER_FLAG = 4;
    localparam int ASFI_B_TX_OVERRUN_FLAG = 5;
    localparam int ASFI_B_FLUSH = 0;

    localparam logic [ASFI_STW-1:0] ASFI_MASK_RST = 6'h33;
    localparam logic [ASFI_STW-1:0] ASFI_MASK_USED = 6'h33;
    localparam logic [ASFI_TRGW-1:0] ASFI_TRIG_RST = 4'h3;
    localparam logic [1:0] ASFI_RESP_OKAY = 2'h0;
    localparam logic [1:0] ASFI_RESP_SLVERR = 2'h2;

    typedef logic [ASFI_NCH-1:0][ASFI_DW-1:0] asfi_chdata_t;

    // Per-FIFO view from the data path: fill level and a one-cycle overrun pulse
    typedef struct packed {
        logic [ASFI_LVLW-1:0] level;
        logic ovf_evt;
    } asfi_fifo_s;

    typedef struct packed {
        logic aw_hold;
        logic [ASFI_AW-1:0] aw_addr;
        logic w_hold;
        logic [ASFI_DW-1:0] w_data;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [ASFI_DW-1:0] rdata;
        logic ovf_rx;
        logic ovf_tx;
        logic avail_rx;
        logic empty_tx;
        logic [ASFI_STW-1:0] mask;
        logic [ASFI_TRGW-1:0] rx_trig;
        logic [ASFI_TRGW-1:0] tx_trig;
        logic rx_flush;
        logic tx_flush;
        logic [ASFI_CHW-1:0] dma_ptr;
        logic dma_pop;
        logic [ASFI_CHW-1:0] dma_ch;
        logic irq;
    } asfi_state_s;
endpackage : asfi_pkg

// ### core/asfi_ch0_ctrl.sv
// Channel-0 FIFO status, interrupt, flush and receive DMA port behind an AXI4-Lite slave
`timescale 1ns/10ps
module asfi_ch0_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [asfi_pkg::ASFI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [asfi_pkg::ASFI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [asfi_pkg::ASFI_AW-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [asfi_pkg::ASFI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire asfi_pkg::asfi_fifo_s rx_fifo,
    input wire asfi_pkg::asfi_fifo_s tx_fifo,
    input wire logic [asfi_pkg::ASFI_NCH-1:0] rx_chan_en,
    input wire asfi_pkg::asfi_chdata_t rx_chan_data,
    output logic rx_fifo_flush,
    output logic tx_fifo_flush,
    output logic rx_dma_pop,
    output logic [asfi_pkg::ASFI_CHW-1:0] rx_dma_ch,
    output logic irq
);
    import asfi_pkg::*;

    asfi_state_s state_ff;
    asfi_state_s nxt_state;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_go;
    logic clr_rx;
    logic clr_tx;
    logic [ASFI_CHW-1:0] dma_pick;

    // Status word in register layout
    function automatic logic [ASFI_STW-1:0] asfi_status(input asfi_state_s s);
        logic [ASFI_STW-1:0] v;
        v = '0;
        v[ASFI_B_RX_DATA_AVAIL_FLAG] = s.avail_rx;
        v[ASFI_B_RX_OVERRUN_FLAG] = s.ovf_rx;
        v[ASFI_B_TX_EMPTY_TRIGGER_FLAG] = s.empty_tx;
        v[ASFI_B_TX_OVERRUN_FLAG] = s.ovf_tx;
        return v;
    endfunction : asfi_status

    // First enabled channel at or after a start point, searching cyclically
    function automatic logic [ASFI_CHW-1:0] asfi_first_en(input logic [ASFI_NCH-1:0] en,
                                                          input logic [ASFI_CHW-1:0] from);
        logic [ASFI_CHW-1:0] pick;
        logic [ASFI_CHW-1:0] cand;
        logic found;
        pick = from;
        found = 1'b0;
        for (int i = 0; i < ASFI_NCH; i++) begin
            cand = ASFI_CHW'(from + ASFI_CHW'(i));
            if (!found && en[cand]) begin
                pick = cand;
                found = 1'b1;
            end
        end
        return pick;
    endfunction : asfi_first_en

    assign s_axi_awready = !state_ff.aw_hold;
    assign s_axi_wready = !state_ff.w_hold;
    assign s_axi_arready = !state_ff.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_go = state_ff.aw_hold && state_ff.w_hold && !state_ff.bvalid;
    assign dma_pick = asfi_first_en(rx_chan_en, state_ff.dma_ptr);

    assign s_axi_bvalid = state_ff.bvalid;
    assign s_axi_bresp = state_ff.bresp;
    assign s_axi_rvalid = state_ff.rvalid;
    assign s_axi_rdata = state_ff.rdata;
    assign s_axi_rresp = state_ff.rresp;
    assign rx_fifo_flush = state_ff.rx_flush;
    assign tx_fifo_flush = state_ff.tx_flush;
    assign rx_dma_pop = state_ff.dma_pop;
    assign rx_dma_ch = state_ff.dma_ch;
    assign irq = state_ff.irq;

    always_comb begin
        nxt_state = state_ff;
        clr_rx = 1'b0;
        clr_tx = 1'b0;
        nxt_state.rx_flush = 1'b0;
        nxt_state.tx_flush = 1'b0;
        nxt_state.dma_pop = 1'b0;

        // Address and data are captured independently, in either order
        if (aw_hs) begin
            nxt_state.aw_hold = 1'b1;
            nxt_state.aw_addr = s_axi_awaddr;
        end
        if (w_hs) begin
            nxt_state.w_hold = 1'b1;
            nxt_state.w_data = s_axi_wdata;
            nxt_state.w_strb0 = s_axi_wstrb[0];
        end
        if (state_ff.bvalid && s_axi_bready) begin
            nxt_state.bvalid = 1'b0;
        end

        if (wr_go) begin
            nxt_state.aw_hold = 1'b0;
            nxt_state.w_hold = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = ASFI_RESP_OKAY;
            unique case (state_ff.aw_addr)
                ASFI_OFF_MASK: begin
                    if (state_ff.w_strb0) begin
                        nxt_state.mask = state_ff.w_data[ASFI_STW-1:0] & ASFI_MASK_USED;
                    end
                end
                ASFI_OFF_RX_TRIG: begin
                    if (state_ff.w_strb0) begin
                        nxt_state.rx_trig = state_ff.w_data[ASFI_TRGW-1:0];
                    end
                end
                ASFI_OFF_TX_TRIG: begin
                    if (state_ff.w_strb0) begin
                        nxt_state.tx_trig = state_ff.w_data[ASFI_TRGW-1:0];
                    end
                end
                ASFI_OFF_RX_FLUSH: begin
                    nxt_state.rx_flush = state_ff.w_strb0 && state_ff.w_data[ASFI_B_FLUSH];
                end
                ASFI_OFF_TX_FLUSH: begin
                    nxt_state.tx_flush = state_ff.w_strb0 && state_ff.w_data[ASFI_B_FLUSH];
                end
                ASFI_OFF_CLEAR: begin
                    clr_rx = state_ff.w_strb0 && state_ff.w_data[ASFI_B_RX_OVERRUN_FLAG];
                    clr_tx = state_ff.w_strb0 && state_ff.w_data[ASFI_B_TX_OVERRUN_FLAG];
                end
                ASFI_OFF_STATUS, ASFI_OFF_RX_OVR, ASFI_OFF_TX_OVR, ASFI_OFF_RX_DMA: begin
                    nxt_state.bresp = ASFI_RESP_OKAY;
                end
                default: begin
                    nxt_state.bresp = ASFI_RESP_SLVERR;
                end
            endcase
        end

        if (state_ff.rvalid && s_axi_rready) begin
            nxt_state.rvalid = 1'b0;
        end
        if (ar_hs) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp = ASFI_RESP_OKAY;
            nxt_state.rdata = '0;
            unique case (s_axi_araddr)
                ASFI_OFF_STATUS: nxt_state.rdata = ASFI_DW'(asfi_status(state_ff));
                ASFI_OFF_MASK: nxt_state.rdata = ASFI_DW'(state_ff.mask);
                ASFI_OFF_RX_OVR: begin
                    // read returns and clears receive overrun
                    nxt_state.rdata = ASFI_DW'(state_ff.ovf_rx);
                    clr_rx = 1'b1;
                end
                ASFI_OFF_TX_OVR: begin
                    // read returns and clears transmit overrun
                    nxt_state.rdata = ASFI_DW'(state_ff.ovf_tx);
                    clr_tx = 1'b1;
                end
                ASFI_OFF_RX_TRIG: nxt_state.rdata = ASFI_DW'(state_ff.rx_trig);
                ASFI_OFF_TX_TRIG: nxt_state.rdata = ASFI_DW'(state_ff.tx_trig);
                ASFI_OFF_RX_FLUSH, ASFI_OFF_TX_FLUSH, ASFI_OFF_CLEAR: begin
                    nxt_state.rdata = '0;
                end
                ASFI_OFF_RX_DMA: begin
                    // step to next enabled channel and wrap
                    if (|rx_chan_en) begin
                        nxt_state.rdata = rx_chan_data[dma_pick];
                        nxt_state.dma_pop = 1'b1;
                        nxt_state.dma_ch = dma_pick;
                        nxt_state.dma_ptr = ASFI_CHW'(dma_pick + ASFI_CHW'(1));
                    end
                end
                default: begin
                    nxt_state.rresp = ASFI_RESP_SLVERR;
                end
            endcase
        end

        // sticky overruns, a new event beats a clear
        nxt_state.ovf_rx = (state_ff.ovf_rx && !clr_rx) || rx_fifo.ovf_evt;
        nxt_state.ovf_tx = (state_ff.ovf_tx && !clr_tx) || tx_fifo.ovf_evt;
        nxt_state.avail_rx = rx_fifo.level >= ASFI_LVLW'(state_ff.rx_trig);
        nxt_state.empty_tx = tx_fifo.level <= ASFI_LVLW'(state_ff.tx_trig);
        nxt_state.irq = |(asfi_status(nxt_state) & ~nxt_state.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= '0;
            state_ff.mask <= ASFI_MASK_RST;
            state_ff.rx_trig <= ASFI_TRIG_RST;
            state_ff.tx_trig <= ASFI_TRIG_RST;
            state_ff.empty_tx <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_to(logic [ASFI_AW-1:0] off);
        wr_go && state_ff.aw_addr == off && state_ff.w_strb0;
    endsequence
    sequence one_pulse(logic sig);
        sig ##1 !sig;
    endsequence

    // A read or a clear write right after the event may drop the flag one cycle later
    rx_ovf_set_a: assert property (rx_fifo.ovf_evt |=> state_ff.ovf_rx
        ##1 (state_ff.ovf_rx || $past(clr_rx)))
        else $error("receive overrun flag not held after event");
    rx_avail_lvl_a: assert property (1'b1 |=> state_ff.avail_rx ==
        ($past(rx_fifo.level) >= ASFI_LVLW'($past(state_ff.rx_trig))))
        else $error("receive data available does not follow level");
    mask_reset_a: assert property ($rose(aresetn) |-> state_ff.mask == ASFI_MASK_RST
        && state_ff.rx_trig == ASFI_TRIG_RST && state_ff.empty_tx)
        else $error("reset values wrong");
    ror_clear_a: assert property (ar_hs && s_axi_araddr == ASFI_OFF_RX_OVR && !rx_fifo.ovf_evt
        |=> !state_ff.ovf_rx && s_axi_rvalid && s_axi_rdata == ASFI_DW'($past(state_ff.ovf_rx)))
        else $error("receive overrun read did not return and clear");
    tor_clear_a: assert property (ar_hs && s_axi_araddr == ASFI_OFF_TX_OVR && !tx_fifo.ovf_evt
        |=> !state_ff.ovf_tx && s_axi_rdata == ASFI_DW'($past(state_ff.ovf_tx)))
        else $error("transmit overrun read did not return and clear");
    rx_trig_wr_a: assert property (wr_to(ASFI_OFF_RX_TRIG)
        |=> state_ff.rx_trig == $past(state_ff.w_data[ASFI_TRGW-1:0]) && s_axi_bvalid)
        else $error("receive trigger write lost");
    tx_empty_lvl_a: assert property (1'b1 |=> state_ff.empty_tx ==
        ($past(tx_fifo.level) <= ASFI_LVLW'($past(state_ff.tx_trig))))
        else $error("transmit empty threshold does not follow level");
    rx_flush_pulse_a: assert property (wr_to(ASFI_OFF_RX_FLUSH) ##0 state_ff.w_data[ASFI_B_FLUSH]
        |=> one_pulse(rx_fifo_flush))
        else $error("receive flush not a single pulse");
    tx_flush_pulse_a: assert property (wr_to(ASFI_OFF_TX_FLUSH) ##0 state_ff.w_data[ASFI_B_FLUSH]
        |=> one_pulse(tx_fifo_flush))
        else $error("transmit flush not a single pulse");
    dma_step_a: assert property (ar_hs && s_axi_araddr == ASFI_OFF_RX_DMA && |rx_chan_en
        |=> rx_dma_pop && rx_chan_en[rx_dma_ch] && rx_dma_ch == $past(dma_pick)
        && state_ff.dma_ptr == ASFI_CHW'(rx_dma_ch + ASFI_CHW'(1)))
        else $error("receive DMA port did not step to enabled channel");
    irq_level_a: assert property (1'b1 |=> irq == |(asfi_status(state_ff) & ~state_ff.mask))
        else $error("interrupt output disagrees with masked status");
    tx_ovf_set_a: assert property (tx_fifo.ovf_evt |=> state_ff.ovf_tx)
        else $error("transmit overrun flag not set");
    rx_set_wins_a: assert property (rx_fifo.ovf_evt && clr_rx |=> state_ff.ovf_rx)
        else $error("receive overrun clear beat a new event");
    tx_set_wins_a: assert property (tx_fifo.ovf_evt && clr_tx |=> state_ff.ovf_tx)
        else $error("transmit overrun clear beat a new event");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed before it was taken");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer changed before it was taken");
endmodule : asfi_ch0_ctrl

// ### test/asfi_host.sv
// AXI4-Lite master model standing for the processor on the register bus
`timescale 1ns/10ps
module asfi_host (
    input wire logic aclk,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [asfi_pkg::ASFI_AW-1:0] s_axi_awaddr,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    output logic [asfi_pkg::ASFI_DW-1:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    output logic [asfi_pkg::ASFI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    input wire logic [asfi_pkg::ASFI_DW-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    import asfi_pkg::*;
    initial begin
        s_axi_awvalid = 1'b0;
        s_axi_awaddr = '0;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_araddr = '0;
        s_axi_rready = 1'b0;
    end
    // Released lines show the inverse so stale values cannot pass
    task automatic wr(input logic [ASFI_AW-1:0] a, input logic [ASFI_DW-1:0] d,
                      output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ASFI_AW-1:0] a, output logic [ASFI_DW-1:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : asfi_host

// ### test/asfi_ch0_ctrl_bench.sv
// Self-checking bench: register and status model compared with the block
`timescale 1ns/10ps
module asfi_ch0_ctrl_bench;
    import asfi_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [ASFI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [ASFI_DW-1:0] s_axi_wdata, s_axi_rdata, rd, v;
    logic [ASFI_DW-1:0] dat[4];
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, rx_dma_ch;
    asfi_fifo_s rx_fifo, tx_fifo;
    logic [ASFI_NCH-1:0] rx_chan_en;
    asfi_chdata_t rx_chan_data;
    logic rx_fifo_flush, tx_fifo_flush, rx_dma_pop, irq, ovf_rx, ovf_tx;
    int msk, rtrg, ttrg, ptr, hit, r0, t0;
    int n_rfl = 0, n_tfl = 0, n_pop = 0, err_total = 0, check_count = 0;
    localparam logic [ASFI_AW-1:0] OFFS[9] = '{ASFI_OFF_STATUS, ASFI_OFF_MASK, ASFI_OFF_RX_OVR,
        ASFI_OFF_TX_OVR, ASFI_OFF_STATUS, ASFI_OFF_RX_TRIG, ASFI_OFF_TX_TRIG,
        ASFI_OFF_RX_FLUSH, ASFI_OFF_TX_FLUSH};
    asfi_ch0_ctrl u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rx_fifo, .tx_fifo, .rx_chan_en,
        .rx_chan_data, .rx_fifo_flush, .tx_fifo_flush, .rx_dma_pop, .rx_dma_ch, .irq);
    asfi_host u_host (.aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (rx_fifo_flush === 1'b1) n_rfl++;
        if (tx_fifo_flush === 1'b1) n_tfl++;
        if (rx_dma_pop === 1'b1) n_pop++;
    end
    function automatic logic [31:0] exp_stat();
        logic [31:0] s;
        s = '0;
        s[0] = rx_fifo.level >= rtrg;
        s[1] = ovf_rx;
        s[4] = tx_fifo.level <= ttrg;
        s[5] = ovf_tx;
        return s;
    endfunction : exp_stat
    function automatic logic [31:0] exp_reg(input logic [ASFI_AW-1:0] a);
        case (a)
            ASFI_OFF_STATUS: return exp_stat();
            ASFI_OFF_MASK: return msk;
            ASFI_OFF_RX_OVR: return 32'(ovf_rx);
            ASFI_OFF_TX_OVR: return 32'(ovf_tx);
            ASFI_OFF_RX_TRIG: return rtrg;
            ASFI_OFF_TX_TRIG: return ttrg;
            default: return 32'h0;
        endcase
    endfunction : exp_reg
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t bit got %h exp %h", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic rd_chk(input logic [ASFI_AW-1:0] a, input logic [1:0] er);
        logic [31:0] e;
        e = exp_reg(a);
        u_host.rd(a, rd, resp);
        cmp_val(rd, e);
        cmp_val(32'(resp), 32'(er));
        if (a == ASFI_OFF_RX_OVR) ovf_rx = 1'b0;
        if (a == ASFI_OFF_TX_OVR) ovf_tx = 1'b0;
        cmp_bit(irq, |(exp_stat() & ~msk & 32'h33));
    endtask : rd_chk
    task automatic wr_chk(input logic [ASFI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
        u_host.wr(a, d, resp);
        cmp_val(32'(resp), 32'(er));
        if (a == ASFI_OFF_MASK) msk = d & 32'h33;
        if (a == ASFI_OFF_RX_TRIG) rtrg = d & 32'hF;
        if (a == ASFI_OFF_TX_TRIG) ttrg = d & 32'hF;
        if (a == ASFI_OFF_CLEAR && d[1]) ovf_rx = 1'b0;
        if (a == ASFI_OFF_CLEAR && d[5]) ovf_tx = 1'b0;
    endtask : wr_chk
    task automatic complete_run();
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        complete_run();
    end
    initial begin
        aresetn = 1'b0;
        rx_fifo = '0;
        tx_fifo = '0;
        rx_chan_en = '0;
        rx_chan_data = '0;
        {ovf_rx, ovf_tx} = 2'h0;
        msk = 32'h33;
        rtrg = 3;
        ttrg = 3;
        ptr = 0;
        v = $urandom(57456);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (OFFS[i]) rd_chk(OFFS[i], ASFI_RESP_OKAY);
        rd_chk(12'h100, ASFI_RESP_SLVERR);
        wr_chk(12'h104, 32'hFFFFFFFF, ASFI_RESP_SLVERR);
        for (int k = 0; k < 16; k++) begin
            wr_chk(ASFI_OFF_MASK, $urandom, ASFI_RESP_OKAY);
            wr_chk(ASFI_OFF_RX_TRIG, $urandom, ASFI_RESP_OKAY);
            wr_chk(ASFI_OFF_TX_TRIG, $urandom, ASFI_RESP_OKAY);
            wr_chk(ASFI_OFF_CLEAR, $urandom, ASFI_RESP_OKAY);
            wr_chk(ASFI_OFF_STATUS, $urandom, ASFI_RESP_OKAY);
            v = $urandom;
            rx_fifo <= v[5:0];
            tx_fifo <= v[11:6];
            @(posedge aclk);
            rx_fifo.ovf_evt <= 1'b0;
            tx_fifo.ovf_evt <= 1'b0;
            ovf_rx = ovf_rx | v[0];
            ovf_tx = ovf_tx | v[6];
            foreach (OFFS[i]) rd_chk(OFFS[i], ASFI_RESP_OKAY);
        end
        rx_chan_en <= '0;
        for (int i = 0; i < 4; i++) begin
            r0 = n_rfl;
            t0 = n_tfl;
            wr_chk(i[1] ? ASFI_OFF_TX_FLUSH : ASFI_OFF_RX_FLUSH, 32'(i[0]), ASFI_RESP_OKAY);
            @(posedge aclk);
            cmp_val(n_rfl, r0 + (i == 1));
            cmp_val(n_tfl, t0 + (i == 3));
        end
        for (int k = 0; k < 12; k++) begin
            v = $urandom;
            for (int j = 0; j < 4; j++) dat[j] = $urandom;
            rx_chan_en <= v[3:0];
            rx_chan_data <= {dat[3], dat[2], dat[1], dat[0]};
            hit = -1;
            for (int j = 3; j >= 0; j--) if (v[(ptr + j) % 4]) hit = (ptr + j) % 4;
            r0 = n_pop;
            u_host.rd(ASFI_OFF_RX_DMA, rd, resp);
            cmp_val(rd, hit < 0 ? 32'h0 : dat[hit]);
            @(posedge aclk);
            cmp_val(n_pop, r0 + (hit >= 0));
            if (hit >= 0) begin
                cmp_val(32'(rx_dma_ch), hit);
                ptr = (hit + 1) % 4;
            end
        end
        complete_run();
    end
endmodule : asfi_ch0_ctrl_bench
